/* design/abpu_pkg.sv */
package abpu_pkg;

  // ----------------------------------------------------------------
  // Register window and offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] WINDOW_TAG     = 16'hff00;
  localparam logic [31:0] OFF_STATUS     = 32'hff000010;
  localparam logic [31:0] OFF_CH0_ADDR   = 32'hff000020;
  localparam logic [31:0] OFF_CH0_CTRL   = 32'hff000024;
  localparam logic [31:0] OFF_CH0_MASK   = 32'hff000028;
  localparam logic [31:0] OFF_CH1_ADDR   = 32'hff000030;
  localparam logic [31:0] OFF_CH1_CTRL   = 32'hff000034;
  localparam logic [31:0] OFF_CH1_MASK   = 32'hff000038;

  // ----------------------------------------------------------------
  // Decode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_ADDR0  = 3'h2;
  localparam logic [2:0] SEL_CTRL0  = 3'h3;
  localparam logic [2:0] SEL_MASK0  = 3'h4;
  localparam logic [2:0] SEL_ADDR1  = 3'h5;
  localparam logic [2:0] SEL_CTRL1  = 3'h6;
  localparam logic [2:0] SEL_MASK1  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FETCH_QUALIFY_BIT       = 9;
  localparam int WRITE_QUALIFY_BIT       = 8;
  localparam int READ_QUALIFY_BIT        = 7;
  localparam int USER_MODE_QUALIFY_BIT   = 6;
  localparam int KERNEL_MODE_QUALIFY_BIT = 5;
  localparam int EXCLUSIVE_SELECT_BIT    = 9;
  localparam int MASTER_ENABLE_BIT       = 8;
  localparam int ADDR_LSB                = 2;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_WMASK   = 32'hfffffffc;
  localparam logic [31:0] CTRL_WMASK   = 32'h000003e0;
  localparam logic [31:0] STATUS_WMASK = 32'h00000303;
  localparam logic [31:0] RESET_WORD   = 32'h00000000;
  localparam logic [1:0]  FLAGS_RESET  = 2'h0;

endpackage

/* design/abpu_chan.sv */
`timescale 1ns/1ns

module abpu_chan (
  input  wire logic [31:0] match_address,
  input  wire logic [31:0] compare_mask,
  input  wire logic [31:0] qualifier_control,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_fetch,
  input  wire logic        acc_read,
  input  wire logic        acc_write,
  input  wire logic        acc_user,
  output logic             hit
);

  logic addr_eq;
  logic type_ok;
  logic mode_ok;

  // ----------------------------------------------------------------
  // Masked compare, bits 31:2 only
  // ----------------------------------------------------------------
  assign addr_eq = ((acc_addr[31:abpu_pkg::ADDR_LSB] ^ match_address[31:abpu_pkg::ADDR_LSB])
                    & compare_mask[31:abpu_pkg::ADDR_LSB]) == '0;

  assign type_ok = (acc_fetch & qualifier_control[abpu_pkg::FETCH_QUALIFY_BIT])
                 | (acc_write & qualifier_control[abpu_pkg::WRITE_QUALIFY_BIT])
                 | (acc_read  & qualifier_control[abpu_pkg::READ_QUALIFY_BIT]);

  assign mode_ok = (acc_user  & qualifier_control[abpu_pkg::USER_MODE_QUALIFY_BIT])
                 | (!acc_user & qualifier_control[abpu_pkg::KERNEL_MODE_QUALIFY_BIT]);

  assign hit = addr_eq & type_ok & mode_ok;

endmodule

/* design/abpu_top.sv */
`timescale 1ns/1ns

//
// Contract
// - Two channels, each a break address over bits 31:2, compared to virtual address.
// - Only mask bits set to one take part in the compare.
// - Unused register bits read zero and ignore writes.
// - Control bit 9 enables compare on instruction fetches.
// - Control bit 8 enables compare on data writes.
// - Control bit 7 enables compare on data reads.
// - Control bit 6 enables compare in user mode.
// - Control bit 5 enables compare in kernel mode.
// - Any mix of the five qualifier bits may be set together.
// - Status bit 9 set: request only when exactly one channel matches.
// - Status bit 9 clear: request when either or both channels match.
// - Status bit 8 enables requests and resets to zero.
// - On an exception, status bits 1:0 load the per-channel match results.
// - Match flags hold while the master enable is zero.
// - Match flags hold in exclusive mode when both channels match.
// - Writing zero to a match flag clears it.
// - Fetch or read violation reports the load refill exception.
// - Store violation reports the store refill exception.
// - Higher priority event wins, but match flags are still set.
// - Seven registers decoded at their kernel space addresses.
// - Window accesses ignore external acknowledge and bus error inputs.
module abpu_top #(
  parameter int NUM_CHAN = 2
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        ACC_VALID,
  input  wire logic [31:0] ACC_ADDR,
  input  wire logic        ACC_FETCH,
  input  wire logic        ACC_READ,
  input  wire logic        ACC_WRITE,
  input  wire logic        ACC_USER,
  input  wire logic [31:0] ACC_WDATA,
  input  wire logic        PRIO_EVENT,
  output logic             LOAD_REFILL_EXC,
  output logic             STORE_REFILL_EXC,
  output logic             EXT_RESP_IGNORE,
  output logic [31:0]      REG_RDATA,
  output logic             REG_RVALID
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CHAN != 2) begin : g_bad_chan
    $error("abpu_top serves exactly two channels");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [2:0] s;
    s = abpu_pkg::SEL_NONE;
    case (a)
      abpu_pkg::OFF_STATUS:   s = abpu_pkg::SEL_STATUS;
      abpu_pkg::OFF_CH0_ADDR: s = abpu_pkg::SEL_ADDR0;
      abpu_pkg::OFF_CH0_CTRL: s = abpu_pkg::SEL_CTRL0;
      abpu_pkg::OFF_CH0_MASK: s = abpu_pkg::SEL_MASK0;
      abpu_pkg::OFF_CH1_ADDR: s = abpu_pkg::SEL_ADDR1;
      abpu_pkg::OFF_CH1_CTRL: s = abpu_pkg::SEL_CTRL1;
      abpu_pkg::OFF_CH1_MASK: s = abpu_pkg::SEL_MASK1;
      default:                s = abpu_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  logic [31:0] addr_r   [2];
  logic [31:0] ctrl_r   [2];
  logic [31:0] mask_r   [2];
  logic        excl_r;
  logic        men_r;
  logic [1:0]  flags_r;
  logic [1:0]  flags_nxt;
  logic [1:0]  hit_vec;
  logic        in_window;
  logic        wr_any;
  logic        rd_any;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic        st_wr;
  logic        any_hit;
  logic        req;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign in_window = ACC_VALID && (ACC_ADDR[31:16] == abpu_pkg::WINDOW_TAG);
  assign wr_any    = in_window && ACC_WRITE;
  assign rd_any    = in_window && ACC_READ;
  assign wsel      = wr_any ? reg_sel(ACC_ADDR) : abpu_pkg::SEL_NONE;
  assign rsel      = reg_sel(ACC_ADDR);
  assign st_wr     = (wsel == abpu_pkg::SEL_STATUS);

  // Window traffic still runs the bus, but the reply comes from here
  assign EXT_RESP_IGNORE = in_window;

  // ----------------------------------------------------------------
  // Channel registers and comparators
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    localparam logic [2:0] SA = (c == 0) ? abpu_pkg::SEL_ADDR0 : abpu_pkg::SEL_ADDR1;
    localparam logic [2:0] SC = (c == 0) ? abpu_pkg::SEL_CTRL0 : abpu_pkg::SEL_CTRL1;
    localparam logic [2:0] SM = (c == 0) ? abpu_pkg::SEL_MASK0 : abpu_pkg::SEL_MASK1;

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        addr_r[c] <= abpu_pkg::RESET_WORD;
        ctrl_r[c] <= abpu_pkg::RESET_WORD;
        mask_r[c] <= abpu_pkg::RESET_WORD;
      end else begin
        // Unused bits never stored, so they read back zero
        if (wsel == SA) begin
          addr_r[c] <= ACC_WDATA & abpu_pkg::ADDR_WMASK;
        end
        if (wsel == SC) begin
          ctrl_r[c] <= ACC_WDATA & abpu_pkg::CTRL_WMASK;
        end
        if (wsel == SM) begin
          mask_r[c] <= ACC_WDATA & abpu_pkg::ADDR_WMASK;
        end
      end
    end

    abpu_chan u_chan (
      .match_address     (addr_r[c]),
      .compare_mask      (mask_r[c]),
      .qualifier_control (ctrl_r[c]),
      .acc_addr          (ACC_ADDR),
      .acc_fetch         (ACC_FETCH),
      .acc_read          (ACC_READ),
      .acc_write         (ACC_WRITE),
      .acc_user          (ACC_USER),
      .hit               (hit_vec[c])
    );
  end

  // ----------------------------------------------------------------
  // Exception request
  // ----------------------------------------------------------------
  assign any_hit = excl_r ? (hit_vec[0] ^ hit_vec[1])
                          : (hit_vec[0] | hit_vec[1]);
  assign req     = ACC_VALID && men_r && any_hit;

  // Higher priority event takes the core; status still records
  assign LOAD_REFILL_EXC  = req && !PRIO_EVENT && (ACC_FETCH || ACC_READ);
  assign STORE_REFILL_EXC = req && !PRIO_EVENT && ACC_WRITE;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (st_wr) begin
      flags_nxt = flags_r & ACC_WDATA[1:0];
    end
    // Load after the clear so a new event is never lost
    if (req) begin
      flags_nxt = hit_vec;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      excl_r <= 1'b0;
      men_r  <= 1'b0;
    end else if (st_wr) begin
      excl_r <= ACC_WDATA[abpu_pkg::EXCLUSIVE_SELECT_BIT];
      men_r  <= ACC_WDATA[abpu_pkg::MASTER_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flags_r <= abpu_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = abpu_pkg::RESET_WORD;
    status_word[abpu_pkg::EXCLUSIVE_SELECT_BIT] = excl_r;
    status_word[abpu_pkg::MASTER_ENABLE_BIT]    = men_r;
    status_word[1:0]                            = flags_r;
    case (rsel)
      abpu_pkg::SEL_STATUS: rd_word = status_word & abpu_pkg::STATUS_WMASK;
      abpu_pkg::SEL_ADDR0:  rd_word = addr_r[0];
      abpu_pkg::SEL_CTRL0:  rd_word = ctrl_r[0];
      abpu_pkg::SEL_MASK0:  rd_word = mask_r[0];
      abpu_pkg::SEL_ADDR1:  rd_word = addr_r[1];
      abpu_pkg::SEL_CTRL1:  rd_word = ctrl_r[1];
      abpu_pkg::SEL_MASK1:  rd_word = mask_r[1];
      default:              rd_word = abpu_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= abpu_pkg::RESET_WORD;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= rd_any;
      if (rd_any) begin
        REG_RDATA <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_both_hit;
    ACC_VALID && hit_vec[0] && hit_vec[1];
  endsequence

  sequence s_enabled_one_hit;
    ACC_VALID && men_r && (hit_vec[0] != hit_vec[1]);
  endsequence

  property p_excl_both_quiet;
    (s_both_hit and excl_r) |-> !LOAD_REFILL_EXC && !STORE_REFILL_EXC;
  endproperty
  a_excl_both_quiet: assert property (p_excl_both_quiet)
    else $error("Exclusive mode raised a request on a double match");

  property p_or_both_req;
    (s_both_hit and (men_r && !excl_r && !PRIO_EVENT && ACC_READ)) |-> LOAD_REFILL_EXC;
  endproperty
  a_or_both_req: assert property (p_or_both_req)
    else $error("Inclusive mode missed a double match request");

  property p_men_gate;
    !men_r |-> !LOAD_REFILL_EXC && !STORE_REFILL_EXC;
  endproperty
  a_men_gate: assert property (p_men_gate)
    else $error("Request raised while master enable is clear");

  property p_flags_load;
    (s_enabled_one_hit and (ACC_FETCH || ACC_READ || ACC_WRITE)) |=>
      flags_r == $past(hit_vec);
  endproperty
  a_flags_load: assert property (p_flags_load)
    else $error("Match flags not loaded on a protection event");

  property p_flags_hold_men;
    (!men_r && !st_wr) |=> $stable(flags_r);
  endproperty
  a_flags_hold_men: assert property (p_flags_hold_men)
    else $error("Match flags changed while master enable is clear");

  property p_flags_hold_excl;
    (s_both_hit and (excl_r && !st_wr)) |=> $stable(flags_r);
  endproperty
  a_flags_hold_excl: assert property (p_flags_hold_excl)
    else $error("Match flags changed on exclusive double match");

  property p_flag_clear;
    (st_wr && !req) |=> flags_r == ($past(flags_r) & $past(ACC_WDATA[1:0]));
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Writing zero did not clear a match flag");

  property p_store_kind;
    STORE_REFILL_EXC |-> ACC_WRITE && req;
  endproperty
  a_store_kind: assert property (p_store_kind)
    else $error("Store refill raised without a store violation");

  property p_prio_still_sets;
    (req && PRIO_EVENT) |-> !LOAD_REFILL_EXC && !STORE_REFILL_EXC
      ##1 flags_r == $past(hit_vec);
  endproperty
  a_prio_still_sets: assert property (p_prio_still_sets)
    else $error("Priority event handling of match flags is wrong");

  property p_ctrl_write;
    (wsel == abpu_pkg::SEL_CTRL0) |=>
      ctrl_r[0] == ($past(ACC_WDATA) & abpu_pkg::CTRL_WMASK)
      ##1 ($stable(ctrl_r[0]) || $past(wsel == abpu_pkg::SEL_CTRL0));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Control register write stored reserved bits or did not hold");

  property p_readback;
    rd_any && (rsel == abpu_pkg::SEL_MASK1) |=> REG_RVALID && REG_RDATA == mask_r[1];
  endproperty
  a_readback: assert property (p_readback)
    else $error("Mask register read back wrong");

  property p_resp_ignore;
    EXT_RESP_IGNORE == (ACC_VALID && ACC_ADDR[31:16] == 16'hff00);
  endproperty
  a_resp_ignore: assert property (p_resp_ignore)
    else $error("External reply mask wrong for the register window");

endmodule

/* bench/abpu_core_model.sv */
`timescale 1ns/1ns

module abpu_core_model (
  input  wire logic        clk,
  output logic             acc_valid,
  output logic [31:0]      acc_addr,
  output logic             acc_fetch,
  output logic             acc_read,
  output logic             acc_write,
  output logic             acc_user,
  output logic [31:0]      acc_wdata,
  output logic             prio_event,
  input  wire logic        load_exc,
  input  wire logic        store_exc,
  input  wire logic        resp_ignore,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  initial begin
    acc_valid  = 1'b0;
    acc_addr   = 32'h0;
    acc_fetch  = 1'b0;
    acc_read   = 1'b0;
    acc_write  = 1'b0;
    acc_user   = 1'b0;
    acc_wdata  = 32'h0;
    prio_event = 1'b0;
  end

  // ----------------------------------------------------------------
  // One access: held for one cycle, released with inverted lines
  // ----------------------------------------------------------------
  // Released address, user and data lines are inverted so a stale value never looks valid
  task automatic access(input logic [31:0] addr, input logic [2:0] kind, input logic user,
                        input logic [31:0] wdata, input logic prio, input int gap,
                        output logic [3:0] resp, output logic [31:0] rd);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    acc_valid  <= 1'b1;
    acc_addr   <= addr;
    {acc_fetch, acc_read, acc_write} <= kind;
    acc_user   <= user;
    acc_wdata  <= wdata;
    prio_event <= prio;
    @(negedge clk);
    resp[3:1] = {load_exc, store_exc, resp_ignore};
    @(posedge clk);
    acc_valid  <= 1'b0;
    acc_addr   <= ~addr;
    {acc_fetch, acc_read, acc_write} <= 3'h0;
    acc_user   <= ~user;
    acc_wdata  <= ~wdata;
    prio_event <= 1'b0;
    @(negedge clk);
    resp[0] = rvalid;
    rd = rdata;
  endtask
endmodule

/* bench/abpu_top_tb.sv */
`timescale 1ns/1ns

module abpu_top_tb;
  logic        clk;
  logic        rst;
  logic        acc_valid, acc_fetch, acc_read, acc_write, acc_user, prio_event;
  logic [31:0] acc_addr, acc_wdata, reg_rdata;
  logic        load_exc, store_exc, resp_ignore, reg_rvalid;
  logic [3:0]  resp;
  logic [31:0] rd;
  logic [31:0] offs [7];
  int          mismatches;
  int          total_checks;
  int          slow;

  localparam logic [2:0] K_FETCH = 3'h4;
  localparam logic [2:0] K_READ  = 3'h2;
  localparam logic [2:0] K_WRITE = 3'h1;
  localparam logic [31:0] AMASK  = abpu_pkg::ADDR_WMASK;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  abpu_top abpu_top_i (.CLK(clk), .RST(rst), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr),
    .ACC_FETCH(acc_fetch), .ACC_READ(acc_read), .ACC_WRITE(acc_write), .ACC_USER(acc_user),
    .ACC_WDATA(acc_wdata), .PRIO_EVENT(prio_event), .LOAD_REFILL_EXC(load_exc),
    .STORE_REFILL_EXC(store_exc), .EXT_RESP_IGNORE(resp_ignore), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid));

  abpu_core_model abpu_core_model_i (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_fetch(acc_fetch), .acc_read(acc_read), .acc_write(acc_write), .acc_user(acc_user),
    .acc_wdata(acc_wdata), .prio_event(prio_event), .load_exc(load_exc),
    .store_exc(store_exc), .resp_ignore(resp_ignore), .rdata(reg_rdata), .rvalid(reg_rvalid));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic [31:0] a, input logic [2:0] k, input logic u,
                     input logic [31:0] d, input logic p);
    abpu_core_model_i.access(a, k, u, d, p, slow, resp, rd);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(a, K_WRITE, 1'b0, d, 1'b0);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    acc(a, K_READ, 1'b0, 32'h0, 1'b0);
    chk({31'h0, resp[1]}, 32'h1, "window ignore flag");
    chk({31'h0, resp[0]}, 32'h1, "read valid");
    chk(rd, exp, what);
  endtask

  // Response pair is {load, store}
  task automatic exc_chk(input logic [31:0] a, input logic [2:0] k, input logic u,
                         input logic [1:0] exp, input string what);
    acc(a, k, u, 32'h0, 1'b0);
    chk({30'h0, resp[3:2]}, {30'h0, exp}, what);
    chk({31'h0, resp[1]}, 32'h0, "ignore flag outside window");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rd_chk(offs[i], 32'h0, "reset value");
  endtask

  task automatic t_regs();
    // Channels first: an armed status would let these writes hit and set flags
    for (int i = 1; i < 7; i++) wr(offs[i], 32'hffffffff);
    wr(offs[0], 32'hffffffff);
    rd_chk(offs[0], 32'h300, "status reserved bits");
    for (int i = 1; i < 7; i++)
      rd_chk(offs[i], (i % 3 == 2) ? abpu_pkg::CTRL_WMASK : AMASK, "reserved bits");
    wr(32'hff00002c, 32'h0);
    rd_chk(offs[3], AMASK, "unmapped write ignored");
    rd_chk(32'hff000014, 32'h0, "unmapped read");
    for (int i = 0; i < 7; i++) wr(offs[i], 32'h0);
  endtask

  task automatic t_qual();
    logic [31:0] c;
    logic [2:0]  kinds [3];
    logic [1:0]  e;
    kinds = '{K_FETCH, K_WRITE, K_READ};
    wr(offs[1], 32'h00001000);
    wr(offs[3], AMASK);
    wr(offs[0], 32'h100);
    for (int j = 0; j < 3; j++) begin
      for (int u = 0; u < 2; u++) begin
        c = 32'h0;
        c[9 - j] = 1'b1;
        c[u ? 6 : 5] = 1'b1;
        wr(offs[2], c);
        for (int k = 0; k < 3; k++) begin
          for (int m = 0; m < 2; m++) begin
            e = (k == j && m == u) ? ((k == 1) ? 2'b01 : 2'b10) : 2'b00;
            exc_chk(32'h00001000, kinds[k], m[0], e, "qualifier table");
          end
        end
      end
    end
    wr(offs[2], abpu_pkg::CTRL_WMASK);
    for (int k = 0; k < 3; k++)
      exc_chk(32'h00001000, kinds[k], k == 1, (k == 1) ? 2'b01 : 2'b10, "all qualifiers");
    exc_chk(32'h00001004, K_READ, 1'b0, 2'b00, "address differs");
    wr(offs[4], 32'h00001000);
    wr(offs[6], AMASK);
    wr(offs[5], abpu_pkg::CTRL_WMASK);
    wr(offs[0], 32'h001);
    exc_chk(32'h00001000, K_READ, 1'b0, 2'b00, "master enable off");
    rd_chk(offs[0], 32'h001, "flags held when disabled");
    wr(offs[5], 32'h0);
  endtask

  task automatic t_mask();
    wr(offs[3], 32'hfffff0fc);
    wr(offs[0], 32'h100);
    slow = 2;
    exc_chk(32'h00001f03, K_READ, 1'b0, 2'b10, "masked bits ignored");
    exc_chk(32'h00011000, K_READ, 1'b0, 2'b00, "unmasked bit differs");
    slow = 0;
  endtask

  task automatic t_combine();
    wr(offs[3], AMASK);
    wr(offs[4], 32'h00000000);
    wr(offs[6], 32'hffff0000);
    wr(offs[5], abpu_pkg::CTRL_WMASK);
    wr(offs[0], 32'h100);
    exc_chk(32'h00001000, K_READ, 1'b0, 2'b10, "or mode both hit");
    rd_chk(offs[0], 32'h103, "both flags set");
    wr(offs[0], 32'h102);
    rd_chk(offs[0], 32'h102, "flag cleared by zero");
    wr(offs[0], 32'h300);
    exc_chk(32'h00001000, K_WRITE, 1'b0, 2'b00, "xor mode both hit");
    rd_chk(offs[0], 32'h300, "flags held on double hit");
    exc_chk(32'h00002000, K_WRITE, 1'b0, 2'b01, "xor mode single hit");
    rd_chk(offs[0], 32'h302, "channel one flag");
    wr(offs[0], 32'h100);
    acc(32'h00001000, K_READ, 1'b0, 32'h0, 1'b1);
    chk({30'h0, resp[3:2]}, 32'h0, "priority event wins");
    rd_chk(offs[0], 32'h103, "flags set under priority event");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    mismatches = 0;
    total_checks = 0;
    slow = 0;
    offs = '{32'hff000010, 32'hff000020, 32'hff000024, 32'hff000028,
             32'hff000030, 32'hff000034, 32'hff000038};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_qual();
    t_mask();
    t_combine();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
